// ---- hw/pdf_pkg.sv ----
// constants shared by the paper deck feed controller
package pdf_pkg;
    // register byte offsets on the plain port
    localparam logic [7:0] REG_PICK = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_SIZE = 8'h0C;
    localparam logic [7:0] REG_INFO = 8'h10;
    // sticky status bits, write one to clear
    localparam int ST_NOPICK1 = 0;
    localparam int ST_NOPICK2 = 1;
    localparam int ST_RESID = 2;
    localparam int ST_DOOR = 3;
    localparam int ST_LIFT = 4;
    localparam int ST_ABSENT = 7;
    localparam int ST_W = 8;
    // info register fields
    localparam int INFO_JAMCAS = 0;
    localparam int INFO_BUSY = 2;
    localparam int INFO_DOOR = 3;
    localparam int INFO_PAPER = 4;
    // synchronised pin vector layout
    localparam int PN_DOOR = 0;
    localparam int PN_FEED = 1;
    localparam int PN_SURF = 4;
    localparam int PN_MOUT = 7;
    localparam int PN_END = 10;
    localparam int PN_WID = 19;
    localparam int PN_W = 28;
    // mask reset value, delivery settle count
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [31:0] SYNC_SETTLE = 32'h0000_0004;
    // media size codes as reported to the engine
    typedef enum logic [3:0] {
        SZ_UNKNOWN = 4'h0,
        SZ_EXEC = 4'h1,
        SZ_LETTER = 4'h2,
        SZ_A5 = 4'h3,
        SZ_B5 = 4'h4,
        SZ_A4 = 4'h5,
        SZ_LEDGER = 4'h6,
        SZ_LEGAL = 4'h7,
        SZ_B4 = 4'h8,
        SZ_A3 = 4'h9,
        SZ_UNIV = 4'hA,
        SZ_ABSENT = 4'hF
    } pdf_size_type;
    // timing, plain defaults in milliseconds
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned LIFT_TMO_MS = 5000;
    localparam int unsigned PICK_TMO_MS = 500;
    localparam int unsigned PASS_TMO_MS = 500;
    localparam int unsigned DELIV_MS = 3000;
    localparam int unsigned LIFT_TMO_CYC = LIFT_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned PICK_TMO_CYC = PICK_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned PASS_TMO_CYC = PASS_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned DELIV_CYC = DELIV_MS * (CLK_HZ / 1000);
    localparam logic [3:0] PICK_RETRIES = 4'h1;
endpackage

// ---- hw/pdf_size_dec.sv ----
// media size and presence decoder for one cassette
`timescale 1ns/1ps
`default_nettype none
module pdf_size_dec
    import pdf_pkg::*;
(
    // switches, bit 2 top, bit 0 bottom, 1 = on
    input wire logic [2:0] i_end,
    input wire logic [2:0] i_width,
    // decoded size
    output var pdf_size_type o_size
);
    // pure decode, the caller registers it
    always_comb begin
        unique case ({i_end, i_width})
            6'h3B: o_size = SZ_EXEC;
            6'h39: o_size = SZ_LETTER;
            // rotated A4 and Letter land here too
            6'h3E: o_size = SZ_A5;
            6'h3A: o_size = SZ_B5;
            6'h38: o_size = SZ_A4;
            6'h09: o_size = SZ_LEDGER;
            6'h0E: o_size = SZ_LEGAL;
            6'h0A: o_size = SZ_B4;
            6'h08: o_size = SZ_A3;
            6'h1E: o_size = SZ_UNIV;
            6'h00: o_size = SZ_ABSENT;
            default: o_size = SZ_UNKNOWN;
        endcase
    end
endmodule
`default_nettype wire

// ---- hw/pdf_lifter.sv ----
// stack lifter control for one cassette
`timescale 1ns/1ps
`default_nettype none
module pdf_lifter
    import pdf_pkg::*;
#(
    parameter int unsigned TMO_CYC = LIFT_TMO_CYC
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // cassette sensing
    input wire logic i_present,
    input wire logic i_trigger,
    input wire logic i_surface,
    // motor drive and fault pulse
    output logic o_motor,
    output logic o_fail
);
    typedef enum logic [2:0] {
        LF_IDLE = 3'h1,
        LF_LIFT = 3'h2,
        LF_FAIL = 3'h4
    } pdf_lift_type;
    typedef struct packed {
        pdf_lift_type st;
        logic [31:0] cnt;
        logic motor;
        logic fail;
    } pdf_lstate_type;
    localparam pdf_lstate_type L_RST = '{st: LF_IDLE, default: '0};
    pdf_lstate_type s;
    pdf_lstate_type next_s;

    // lift sequencing
    always_comb begin
        next_s = s;
        next_s.fail = 1'b0;
        unique case (s.st)
            LF_IDLE: begin
                if (i_present && !i_surface) begin
                    next_s.st = LF_LIFT;
                    next_s.cnt = 32'h0;
                    next_s.motor = 1'b1;
                end
            end
            LF_LIFT: begin
                next_s.cnt = s.cnt + 32'h1;
                if (!i_present || i_surface) begin
                    next_s.st = LF_IDLE;
                    next_s.motor = 1'b0;
                end else if (s.cnt >= TMO_CYC - 1) begin
                    next_s.st = LF_FAIL;
                    next_s.motor = 1'b0;
                    next_s.fail = 1'b1;
                end
            end
            LF_FAIL: begin
                // motor stays off until reinstalled, avoids grinding a jammed lifter
                if (i_trigger || !i_present) begin
                    next_s.st = LF_IDLE;
                end
            end
            default: next_s = L_RST;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= L_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_motor = s.motor;
    assign o_fail = s.fail;

    AST_LIFT_STOP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_motor && i_surface |=> !o_motor) else $error("lifter ran past stack");
    AST_LIFT_FAIL: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_fail |-> $past(o_motor) && !o_motor) else $error("lift fault without lift");
endmodule
`default_nettype wire

// ---- hw/pdf_deck_ctrl.sv ----
// paper deck feed controller: size, lift, pickup, jams, registers
//
// How it works
// - three cassettes, same pickup sequence, one sheet per request
// - full-length end switches: width code picks letter-class sizes
// - end pattern off, off, on: width code picks large sizes
// - width on, on, off with end off, on, on is universal
// - all six switches off means absent, flagged to the engine
// - rotated A4 or Letter reads and reports as A5
// - lift at power-on, cassette install and stack drop
// - media-out sensor tells whether a cassette holds paper
// - lifter runs until stack seen, restarts when stack lowers
// - stack not seen in time after lift start is lifter failure
// - three feed sensors give paper presence and leading edges
// - upper sensor late after lower sensor edge: no-pick jam 1
// - own feed sensor late after solenoid, with retry: no-pick jam 2
// - paper still seen after automatic delivery: residual jam
// - door opened during feed: door-open jam
// - after power-on or door close, leftover paper is delivered out
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pdf_deck_ctrl
    import pdf_pkg::*;
#(
    parameter int unsigned LIFT_CYC = LIFT_TMO_CYC,
    parameter int unsigned PICK_CYC = PICK_TMO_CYC,
    parameter int unsigned PASS_CYC = PASS_TMO_CYC,
    parameter int unsigned DELV_CYC = DELIV_CYC,
    parameter logic [3:0] RETRIES = PICK_RETRIES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    // deck door, high while open
    input wire logic i_deck_door_open_switch,
    // cassette 1 sensing
    input wire logic i_cas1_feed_sensor,
    input wire logic i_cas1_surface_sensor,
    input wire logic i_cas1_media_out_sensor,
    input wire logic [2:0] i_cas1_end_switch,
    input wire logic [2:0] i_cas1_width_switch,
    // cassette 2 sensing
    input wire logic i_cas2_feed_sensor,
    input wire logic i_cas2_surface_sensor,
    input wire logic i_cas2_media_out_sensor,
    input wire logic [2:0] i_cas2_end_switch,
    input wire logic [2:0] i_cas2_width_switch,
    // cassette 3 sensing
    input wire logic i_cas3_feed_sensor,
    input wire logic i_cas3_surface_sensor,
    input wire logic i_cas3_media_out_sensor,
    input wire logic [2:0] i_cas3_end_switch,
    input wire logic [2:0] i_cas3_width_switch,
    // drives
    output logic o_cas1_pickup_motor,
    output logic o_cas1_lifter_motor,
    output logic o_cas1_pickup_solenoid,
    output logic o_cas2_pickup_motor,
    output logic o_cas2_lifter_motor,
    output logic o_cas2_pickup_solenoid,
    output logic o_cas3_pickup_motor,
    output logic o_cas3_lifter_motor,
    output logic o_cas3_pickup_solenoid
);
    typedef enum logic [4:0] {
        MS_IDLE = 5'h01,
        MS_DELIV = 5'h02,
        MS_PICK = 5'h04,
        MS_PASS = 5'h08,
        MS_HOLD = 5'h10
    } pdf_main_type;
    typedef struct packed {
        logic [PN_W-1:0] sync1;
        logic [PN_W-1:0] sync2;
        pdf_main_type st;
        logic [1:0] cas;
        logic [1:0] pos;
        logic [31:0] cnt;
        logic [3:0] tries;
        logic [2:0] feed_d;
        logic [2:0] pres_d;
        logic [2:0] trig;
        logic por;
        logic [11:0] sizes;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [1:0] jam_cas;
        logic [31:0] rdata;
        logic irq;
        logic [2:0] pmotor;
        logic [2:0] sol;
    } pdf_state_type;
    localparam pdf_state_type S_RST = '{st: MS_IDLE, por: 1'b1, sizes: {3{SZ_ABSENT}},
                                        mask: MASK_RST, default: '0};

    pdf_state_type s;
    pdf_state_type next_s;
    logic [PN_W-1:0] pins;
    logic door;
    logic [2:0] feed;
    logic [2:0] surf;
    logic [2:0] mout;
    logic [2:0] present;
    logic [2:0] paper;
    logic [2:0] edge_f;
    logic [2:0] lmotor;
    logic [2:0] lfail;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    logic [1:0] sel;
    logic pick_ok;
    logic [31:0] info;
    pdf_size_type dec_size [3];

    // one-hot of a cassette index
    function automatic logic [2:0] cas_bit(input logic [1:0] c);
        return 3'h1 << c;
    endfunction
    // feed rollers from a cassette up to the printer
    function automatic logic [2:0] cas_upto(input logic [1:0] c);
        return cas_bit(c) | (cas_bit(c) - 3'h1);
    endfunction

    // raw pins, synchronised in the state below
    assign pins = {i_cas3_width_switch, i_cas2_width_switch, i_cas1_width_switch,
                   i_cas3_end_switch, i_cas2_end_switch, i_cas1_end_switch,
                   i_cas3_media_out_sensor, i_cas2_media_out_sensor, i_cas1_media_out_sensor,
                   i_cas3_surface_sensor, i_cas2_surface_sensor, i_cas1_surface_sensor,
                   i_cas3_feed_sensor, i_cas2_feed_sensor, i_cas1_feed_sensor,
                   i_deck_door_open_switch};
    // views of the second synchroniser stage only
    assign door = s.sync2[PN_DOOR];
    assign feed = s.sync2[PN_FEED +: 3];
    assign surf = s.sync2[PN_SURF +: 3];
    assign mout = s.sync2[PN_MOUT +: 3];

    // per-cassette decoder and lifter
    for (genvar g = 0; g < 3; g++) begin : g_cas
        pdf_size_dec u_dec (
            .i_end(s.sync2[PN_END + 3 * g +: 3]),
            .i_width(s.sync2[PN_WID + 3 * g +: 3]),
            .o_size(dec_size[g])
        );
        assign present[g] = s.sizes[4 * g +: 4] != SZ_ABSENT;
        assign paper[g] = present[g] && !mout[g];
        pdf_lifter #(.TMO_CYC(LIFT_CYC)) u_lift (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_present(present[g]),
            .i_trigger(s.trig[g]),
            .i_surface(surf[g]),
            .o_motor(lmotor[g]),
            .o_fail(lfail[g])
        );
    end

    assign edge_f = feed & ~s.feed_d;
    assign clr = (i_wr && i_addr == REG_STATUS) ? i_wdata[ST_W-1:0] : 8'h00;
    assign sel = i_wdata[1:0] - 2'h1;
    // request taken only with paper in the chosen cassette
    assign pick_ok = i_wr && i_addr == REG_PICK && i_wdata[1:0] != 2'h0 && paper[sel];

    // next-state for the whole deck
    always_comb begin
        next_s = s;
        ev = '0;
        info = 32'h0;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.feed_d = feed;
        next_s.pres_d = present;
        next_s.por = 1'b0;
        for (int i = 0; i < 3; i++) begin
            next_s.sizes[4 * i +: 4] = dec_size[i];
        end
        next_s.trig = present & ~s.pres_d;
        ev[ST_ABSENT] = |(s.pres_d & ~present);
        ev[ST_LIFT +: 3] = lfail;
        if (door && (s.st == MS_PICK || s.st == MS_PASS || s.st == MS_DELIV)) begin
            ev[ST_DOOR] = 1'b1;
            next_s.jam_cas = s.st == MS_DELIV ? 2'h0 : s.cas + 2'h1;
            next_s.st = MS_HOLD;
            next_s.pmotor = 3'h0;
            next_s.sol = 3'h0;
        end else begin
            unique case (s.st)
                MS_IDLE: begin
                    if (door) begin
                        next_s.st = MS_HOLD;
                    end else if (s.por) begin
                        next_s.st = MS_DELIV;
                        next_s.cnt = 32'h0;
                    end else if (pick_ok) begin
                        next_s.st = MS_PICK;
                        next_s.cas = sel;
                        next_s.cnt = 32'h0;
                        next_s.tries = 4'h0;
                        next_s.sol = cas_bit(sel);
                        next_s.pmotor = cas_upto(sel);
                    end
                end
                MS_DELIV: begin
                    next_s.cnt = s.cnt + 32'h1;
                    if (s.cnt < SYNC_SETTLE) begin
                        // wait for synchronisers to fill after reset
                        next_s.pmotor = 3'h0;
                    end else if (feed == 3'h0) begin
                        next_s.st = MS_IDLE;
                        next_s.pmotor = 3'h0;
                    end else if (s.cnt >= DELV_CYC - 1) begin
                        ev[ST_RESID] = 1'b1;
                        next_s.jam_cas = 2'h0;
                        next_s.st = MS_IDLE;
                        next_s.pmotor = 3'h0;
                    end else begin
                        next_s.pmotor = 3'h7;
                    end
                end
                MS_PICK: begin
                    next_s.cnt = s.cnt + 32'h1;
                    if (edge_f[s.cas]) begin
                        next_s.st = MS_PASS;
                        next_s.pos = s.cas;
                        next_s.cnt = 32'h0;
                        next_s.sol = 3'h0;
                    end else if (s.cnt >= PICK_CYC - 1) begin
                        if (s.tries < RETRIES) begin
                            next_s.tries = s.tries + 4'h1;
                            next_s.cnt = 32'h0;
                        end else begin
                            ev[ST_NOPICK2] = 1'b1;
                            next_s.jam_cas = s.cas + 2'h1;
                            next_s.st = MS_IDLE;
                            next_s.pmotor = 3'h0;
                            next_s.sol = 3'h0;
                        end
                    end
                end
                MS_PASS: begin
                    next_s.cnt = s.cnt + 32'h1;
                    if (s.pos == 2'h0) begin
                        // sheet at the top sensor, printer takes it over
                        next_s.st = MS_IDLE;
                        next_s.pmotor = 3'h0;
                    end else if (edge_f[s.pos - 2'h1]) begin
                        next_s.pos = s.pos - 2'h1;
                        next_s.cnt = 32'h0;
                    end else if (s.cnt >= PASS_CYC - 1) begin
                        ev[ST_NOPICK1] = 1'b1;
                        next_s.jam_cas = s.pos;
                        next_s.st = MS_IDLE;
                        next_s.pmotor = 3'h0;
                    end
                end
                MS_HOLD: begin
                    next_s.pmotor = 3'h0;
                    next_s.sol = 3'h0;
                    if (!door) begin
                        next_s.st = MS_DELIV;
                        next_s.cnt = 32'h0;
                    end
                end
                default: next_s.st = MS_IDLE;
            endcase
        end
        // mask register and read port
        if (i_wr && i_addr == REG_MASK) begin
            next_s.mask = i_wdata[ST_W-1:0];
        end
        next_s.status = (s.status & ~clr) | ev;
        next_s.irq = |(s.status & s.mask);
        info[INFO_JAMCAS +: 2] = s.jam_cas;
        info[INFO_BUSY] = s.st != MS_IDLE;
        info[INFO_DOOR] = door;
        info[INFO_PAPER +: 3] = paper;
        next_s.rdata = 32'h0;
        if (i_rd) begin
            case (i_addr)
                REG_STATUS: next_s.rdata = {24'h0, s.status};
                REG_MASK: next_s.rdata = {24'h0, s.mask};
                REG_SIZE: next_s.rdata = {20'h0, s.sizes};
                REG_INFO: next_s.rdata = info;
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign o_rdata = s.rdata;
    assign o_irq = s.irq;
    assign o_cas1_pickup_motor = s.pmotor[0];
    assign o_cas2_pickup_motor = s.pmotor[1];
    assign o_cas3_pickup_motor = s.pmotor[2];
    assign o_cas1_pickup_solenoid = s.sol[0];
    assign o_cas2_pickup_solenoid = s.sol[1];
    assign o_cas3_pickup_solenoid = s.sol[2];
    assign o_cas1_lifter_motor = lmotor[0];
    assign o_cas2_lifter_motor = lmotor[1];
    assign o_cas3_lifter_motor = lmotor[2];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_ONE_SOL: assert property ($onehot0(s.sol)) else $error("two solenoids on");
    AST_ABSENT: assert property ($fell(present[0]) |=> s.status[ST_ABSENT])
        else $error("absent not flagged");
    AST_DOOR: assert property (door && (s.st == MS_PICK || s.st == MS_PASS) |=>
        s.st == MS_HOLD && s.status[ST_DOOR] && s.pmotor == 3'h0) else $error("door jam missed");
    AST_REDELIV: assert property (s.st == MS_HOLD && !door |=> s.st == MS_DELIV)
        else $error("no delivery after door close");
    AST_RESID: assert property (s.st == MS_DELIV && !door && feed != 3'h0
        && s.cnt >= DELV_CYC - 1 |=> s.status[ST_RESID] && s.st == MS_IDLE) else $error("residual missed");
    AST_NOPICK2: assert property (s.st == MS_PICK && !door && !edge_f[s.cas]
        && s.cnt >= PICK_CYC - 1 && s.tries >= RETRIES |=> s.status[ST_NOPICK2]
        && s.jam_cas == $past(s.cas) + 2'h1) else $error("no-pick 2 missed");
    AST_NOPICK1: assert property (s.st == MS_PASS && !door && s.pos != 2'h0
        && !edge_f[s.pos - 2'h1] && s.cnt >= PASS_CYC - 1 |=> s.status[ST_NOPICK1] && s.st == MS_IDLE)
        else $error("no-pick 1 missed");
    AST_KEEP: assert property (($past(s.status) & ~s.status & ~$past(clr)) == 8'h00)
        else $error("fault flag lost");
    AST_IRQ: assert property (|(s.status & s.mask) |=> o_irq) else $error("irq not raised");

    COV_PICK_DONE: cover property (s.st == MS_PASS && s.pos == 2'h0);
    COV_NOPICK2: cover property ($rose(s.status[ST_NOPICK2]));
    COV_DELIV: cover property (s.st == MS_DELIV && feed != 3'h0 ##1 s.st == MS_IDLE);
endmodule
`default_nettype wire

// ---- bench/pdf_paper_model.sv ----
// paper path and stack lifter model facing the deck controller
`timescale 1ns/1ps
`default_nettype none
module pdf_paper_model (
    // clock, reset, fault mode
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [2:0] i_mode,
    input wire logic [2:0] i_drop,
    // drives from the deck, bit 0 is cassette 1
    input wire logic [2:0] i_sol,
    input wire logic [2:0] i_lift,
    // sensors back to the deck
    output logic [2:0] o_feed,
    output logic [2:0] o_surf
);
    int age = 0;
    int lc = 0;
    initial o_feed = 3'b000;
    // stack rises, mode 4 jams lifter
    always @(posedge i_clk) begin
        lc <= (|i_lift) ? lc + 1 : 0;
        if (!i_rstn || i_mode == 3'd4) o_surf <= 3'b000;
        else o_surf <= (o_surf | (i_lift & {3{lc > 3}})) & ~i_drop;
    end
    // sheet travel, mode 1 no pick, 2 stall, 3 stuck
    always @(posedge i_clk) begin
        age <= age + 1;
        if (i_mode == 3'd3) o_feed <= 3'b001;
        else if (o_feed == 3'b000) begin
            if (i_sol == 3'b000 || i_mode == 3'd1) age <= 0;
            else if (age > 3) begin
                o_feed <= i_sol;
                age <= 0;
            end
        end else if (age > 3 && i_mode != 3'd2) begin
            o_feed <= o_feed >> 1;
            age <= 0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the paper deck feed controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pdf_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ws = 1'b0, rs = 1'b0, door = 1'b0, irq;
    logic [7:0] a = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [2:0] mo = 3'b000, mode = 3'b000, drop = 3'b000, e1 = 3'b111, w1 = 3'b001;
    logic [2:0] e23 = 3'b111, w23 = 3'b001;
    wire logic [2:0] pm, lm, sol, feed, surf;
    int n_mismatch = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    pdf_deck_ctrl #(.LIFT_CYC(50), .PICK_CYC(20), .PASS_CYC(20), .DELV_CYC(40), .RETRIES(4'h1)) i_dut (
        .i_clk(clk), .i_rstn(rstn), .i_addr(a), .i_wdata(wd), .i_wr(ws), .i_rd(rs), .o_rdata(rdat),
        .o_irq(irq), .i_deck_door_open_switch(door), .i_cas1_feed_sensor(feed[0]),
        .i_cas1_surface_sensor(surf[0]), .i_cas1_media_out_sensor(mo[0]), .i_cas1_end_switch(e1),
        .i_cas1_width_switch(w1), .i_cas2_feed_sensor(feed[1]), .i_cas2_surface_sensor(surf[1]),
        .i_cas2_media_out_sensor(mo[1]), .i_cas2_end_switch(e23), .i_cas2_width_switch(w23),
        .i_cas3_feed_sensor(feed[2]), .i_cas3_surface_sensor(surf[2]), .i_cas3_media_out_sensor(mo[2]),
        .i_cas3_end_switch(e23), .i_cas3_width_switch(w23), .o_cas1_pickup_motor(pm[0]),
        .o_cas1_lifter_motor(lm[0]), .o_cas1_pickup_solenoid(sol[0]), .o_cas2_pickup_motor(pm[1]),
        .o_cas2_lifter_motor(lm[1]), .o_cas2_pickup_solenoid(sol[1]), .o_cas3_pickup_motor(pm[2]),
        .o_cas3_lifter_motor(lm[2]), .o_cas3_pickup_solenoid(sol[2]));
    pdf_paper_model i_model (.i_clk(clk), .i_rstn(rstn), .i_mode(mode), .i_drop(drop), .i_sol(sol),
        .i_lift(lm), .o_feed(feed), .o_surf(surf));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bus cycles: one-cycle strobes, read data the cycle after
    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk);
        a <= ad;
        wd <= v;
        ws <= 1'b1;
        @(posedge clk);
        ws <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        a <= ad;
        rs <= 1'b1;
        @(posedge clk);
        rs <= 1'b0;
        #1;
        d = rdat;
    endtask
    task automatic rc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        rd(ad);
        chk(d & m, e);
    endtask
    task automatic idle;
        rd(REG_INFO);
        for (int k = 0; k < 300 && d[INFO_BUSY] !== 1'b0; k++) rd(REG_INFO);
        chk(d[INFO_BUSY], 1'b0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // mode 3 skips the wait so delivery can be watched
    task automatic rst(input logic [2:0] m);
        @(posedge clk);
        mode <= m;
        door <= 1'b0;
        mo <= 3'b000;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        if (m != 3'd3) idle();
    endtask
    task automatic t_size;
        logic [9:0] tb [11] = '{10'h3B1, 10'h392, 10'h3E3, 10'h3A4, 10'h385, 10'h096, 10'h0E7, 10'h0A8,
            10'h089, 10'h1EA, 10'h00F};
        foreach (tb[k]) begin
            @(posedge clk);
            e1 <= tb[k][9:7];
            w1 <= tb[k][6:4];
            cyc(6);
            rc(REG_SIZE, 32'hFFF, {20'h0, 8'h22, tb[k][3:0]});
        end
        rc(REG_STATUS, 32'h80, 32'h80);
        @(posedge clk);
        e1 <= 3'b111;
        w1 <= 3'b001;
    endtask
    task automatic t_pick;
        rst(3'd0);
        rc(REG_INFO, 32'h70, 32'h70);
        reg_wr(REG_PICK, 32'h3);
        cyc(1);
        chk({sol, pm}, 6'b100111);
        idle();
        chk({sol, pm}, 6'b0);
        rc(REG_STATUS, 32'hF, 32'h0);
        @(posedge clk);
        mo <= 3'b001;
        // let the empty sensor clear both synchroniser stages first
        cyc(4);
        reg_wr(REG_PICK, 32'h1);
        rc(REG_INFO, 32'h14, 32'h0);
    endtask
    task automatic t_nopick;
        rst(3'd1);
        reg_wr(REG_PICK, 32'h2);
        cyc(24);
        chk(sol, 3'b010);
        idle();
        rc(REG_STATUS, 32'hF, 32'h2);
        rc(REG_INFO, 32'h3, 32'h2);
        chk(irq, 1'b0);
        reg_wr(REG_MASK, 32'h2);
        rc(8'hFC, 32'hFFFFFFFF, 32'h0);
        chk(irq, 1'b1);
        reg_wr(REG_STATUS, 32'h2);
        rc(REG_STATUS, 32'hF, 32'h0);
        chk(irq, 1'b0);
        rst(3'd2);
        reg_wr(REG_PICK, 32'h3);
        idle();
        rc(REG_STATUS, 32'hF, 32'h1);
        rc(REG_INFO, 32'h3, 32'h2);
    endtask
    task automatic t_door;
        rst(3'd0);
        reg_wr(REG_PICK, 32'h1);
        @(posedge clk);
        door <= 1'b1;
        cyc(6);
        chk({sol, pm}, 6'b0);
        rc(REG_STATUS, 32'hF, 32'h8);
        rst(3'd3);
        cyc(12);
        chk(pm, 3'b111);
        idle();
        rc(REG_STATUS, 32'hF, 32'h4);
    endtask
    task automatic t_lift;
        rst(3'd0);
        cyc(10);
        chk(lm, 3'b000);
        @(posedge clk);
        drop <= 3'b010;
        @(posedge clk);
        drop <= 3'b000;
        cyc(6);
        chk(lm, 3'b010);
        rst(3'd4);
        chk(lm, 3'b111);
        cyc(60);
        chk(lm, 3'b000);
        rc(REG_STATUS, 32'h70, 32'h70);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst(3'd0);
        t_size();
        t_pick();
        t_nopick();
        t_door();
        t_lift();
        print_verdict();
    end
    // hang guard, well past the longest run
    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
